// File: hdl/status_serial_config.sv
// Status register groups and serial/parallel interface settings
`timescale 1ns/1ps
`include "status_regs.svh"

// Contract
// RQ1 - Status byte bit 7 is OR of enabled operation event bits.
// RQ2 - Operation mask holds only weights 1, 32, 256, 1024; up to 1313.
// RQ3 - Operation event register latches events and clears when read.
// RQ4 - Questionable event register latches events and clears when read.
// RQ5 - Questionable condition shows live conditions, no latching.
// RQ6 - Only questionable bit 3, overtemperature, carries meaning.
// RQ7 - Status byte bit 3 is OR of enabled questionable event bits.
// RQ8 - Preset command clears both enable masks to zero.
// RQ9 - Mask queries return the masks as last written.
// RQ10 - Parallel bus address stored; host supplies 1 to 30.
// RQ11 - Serial rate is one of four selections; query reports it.
// RQ12 - Echo on returns every later received character; query 01/00.
// RQ13 - Echo off takes effect only after next line terminator.
// RQ14 - General reset command leaves echo setting unchanged.
// RQ15 - Pacing XON enables flow control, NONE disables; query 01/00.
// RQ16 - Operation bits: calibration 0, trigger wait 5, constant voltage 8, constant current 10.
// RQ17 - Operation condition register shows live conditions, no latching.
// RQ18 - Event bit sets on condition rising, holds until read.
// RQ19 - Event arriving during a read-clear stays latched for next read.
module status_serial_config (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Decoded commands from the text parser
  input  wire logic              cmd_valid,
  input  wire status_pkg::cmd_t  cmd_code,
  input  wire logic [15:0]       cmd_data,
  // Query answers
  output logic                   resp_valid,
  output logic [15:0]            resp_data,
  // Condition pins, asynchronous
  input  wire logic              calibration_busy_pin,
  input  wire logic              waiting_for_trigger_flag,
  input  wire logic              constant_voltage_flag,
  input  wire logic              constant_current_flag,
  input  wire logic              overtemperature_flag,
  // Status byte summaries
  output logic [7:0]             status_byte,
  // Interface settings
  output logic [4:0]             parallel_bus_address_setting,
  output status_pkg::baud_t      serial_rate_setting,
  output logic                   serial_pacing_setting,
  output logic                   serial_echo_setting,
  // Serial character stream
  input  wire logic              rx_valid,
  input  wire logic [7:0]        rx_char,
  output logic                   echo_valid,
  output logic [7:0]             echo_char
);
  import status_pkg::*;

  // Map a rate value onto its selection; unknown rates are refused
  function automatic logic baud_known(input logic [15:0] v);
    baud_known = (v == `BAUD_19200) || (v == `BAUD_9600) ||
                 (v == `BAUD_4800) || (v == `BAUD_2400);
  endfunction

  function automatic baud_t baud_encode(input logic [15:0] v);
    case (v)
      `BAUD_19200: baud_encode = BAUD_SEL_19200;
      `BAUD_4800:  baud_encode = BAUD_SEL_4800;
      `BAUD_2400:  baud_encode = BAUD_SEL_2400;
      default:     baud_encode = BAUD_SEL_9600;
    endcase
  endfunction

  function automatic logic [15:0] baud_decode(input baud_t s);
    case (s)
      BAUD_SEL_19200: baud_decode = `BAUD_19200;
      BAUD_SEL_4800:  baud_decode = `BAUD_4800;
      BAUD_SEL_2400:  baud_decode = `BAUD_2400;
      default:        baud_decode = `BAUD_9600;
    endcase
  endfunction

  function automatic logic [15:0] bool_answer(input logic b);
    bool_answer = b ? `ANSWER_ON : `ANSWER_OFF;
  endfunction

  // Pin vector onto register bit positions; all other bits stay zero
  function automatic logic [15:0] oper_place(input logic [4:0] v);
    oper_place                        = 16'h0000;
    oper_place[`OPER_BIT_CAL]         = v[0];
    oper_place[`OPER_BIT_TRIG_WAIT]   = v[1];
    oper_place[`OPER_BIT_CONST_VOLT]  = v[2];
    oper_place[`OPER_BIT_CONST_CURR]  = v[3];
  endfunction

  function automatic logic [15:0] ques_place(input logic [4:0] v);
    ques_place                     = 16'h0000;
    ques_place[`QUES_BIT_OVERTEMP] = v[4];
  endfunction

  // Set wins over the read clear, so no event is lost at a read
  function automatic logic [15:0] event_update(input logic [15:0] ev, input logic rd,
                                               input logic [15:0] rise);
    event_update = (rd ? 16'h0000 : ev) | rise;
  endfunction

  function automatic logic summary_of(input logic [15:0] ev, input logic [15:0] mask);
    summary_of = |(ev & mask);
  endfunction

  // A code only counts while its strobe is high
  function automatic logic cmd_hit(input logic v, input cmd_t c, input cmd_t want);
    cmd_hit = v && (c == want);
  endfunction

  // Pin synchronisers; first stage feeds only the second
  logic [4:0] cond_meta_reg;
  logic [4:0] cond_sync_reg;
  logic [4:0] cond_prev_reg;

  // Register state
  logic [15:0] oper_event_reg;
  logic [15:0] oper_event_next;
  logic [15:0] oper_enable_reg;
  logic [15:0] ques_event_reg;
  logic [15:0] ques_event_next;
  logic [15:0] ques_enable_reg;
  logic [4:0]  bus_addr_reg;
  baud_t       baud_reg;
  logic        pace_reg;
  logic        echo_reg;
  logic        resp_valid_reg;
  logic [15:0] resp_data_reg;
  logic [7:0]  status_byte_reg;

  // Raw condition vector, index order fixed by pin list
  wire logic [4:0] cond_pins = {overtemperature_flag, constant_current_flag,
                                constant_voltage_flag, waiting_for_trigger_flag,
                                calibration_busy_pin};

  // Live condition registers built from synchronised pins
  wire logic [15:0] oper_cond = oper_place(cond_sync_reg); // [RQ16] [RQ17]
  wire logic [15:0] ques_cond = ques_place(cond_sync_reg); // [RQ5] [RQ6]

  // Only a rising condition raises an event
  wire logic [4:0]  cond_rise = cond_sync_reg & ~cond_prev_reg; // [RQ18]

  wire logic [15:0] oper_rise = oper_place(cond_rise); // [RQ16]
  wire logic [15:0] ques_rise = ques_place(cond_rise); // [RQ6]

  // Command decode
  wire logic do_cmd        = cmd_valid;
  wire logic rd_oper_event = cmd_hit(do_cmd, cmd_code, CMD_OPER_EVENT_Q);
  wire logic rd_ques_event = cmd_hit(do_cmd, cmd_code, CMD_QUES_EVENT_Q);
  wire logic wr_oper_enab  = cmd_hit(do_cmd, cmd_code, CMD_OPER_ENAB_W);
  wire logic wr_ques_enab  = cmd_hit(do_cmd, cmd_code, CMD_QUES_ENAB_W);
  wire logic do_preset     = cmd_hit(do_cmd, cmd_code, CMD_PRESET);
  wire logic addr_in_range = (cmd_data[15:5] == 11'h000) &&
                             (cmd_data[4:0] >= `ADDR_MIN) &&
                             (cmd_data[4:0] <= `ADDR_MAX);
  wire logic wr_addr       = cmd_hit(do_cmd, cmd_code, CMD_ADDR_W) && addr_in_range;
  wire logic wr_baud       = cmd_hit(do_cmd, cmd_code, CMD_BAUD_W) && baud_known(cmd_data);
  wire logic wr_echo       = cmd_hit(do_cmd, cmd_code, CMD_ECHO_W);
  wire logic wr_pace       = cmd_hit(do_cmd, cmd_code, CMD_PACE_W);

  // Read clears, but a rising edge in the same cycle still lands
  assign oper_event_next = event_update(oper_event_reg, rd_oper_event, oper_rise); // [RQ3] [RQ19]
  assign ques_event_next = event_update(ques_event_reg, rd_ques_event, ques_rise); // [RQ4] [RQ19]

  // Query answer selection; reads show the value before clearing
  logic        answer_valid;
  logic [15:0] answer_data;

  always_comb begin
    answer_valid = do_cmd;
    answer_data  = 16'h0000;
    case (cmd_code)
      CMD_OPER_COND_Q:  answer_data = oper_cond; // [RQ17]
      CMD_OPER_ENAB_Q:  answer_data = oper_enable_reg; // [RQ9]
      CMD_OPER_EVENT_Q: answer_data = oper_event_reg; // [RQ3]
      CMD_QUES_EVENT_Q: answer_data = ques_event_reg; // [RQ4]
      CMD_QUES_COND_Q:  answer_data = ques_cond; // [RQ5]
      CMD_QUES_ENAB_Q:  answer_data = ques_enable_reg; // [RQ9]
      CMD_ADDR_Q:       answer_data = {11'h000, bus_addr_reg}; // [RQ10]
      CMD_BAUD_Q:       answer_data = baud_decode(baud_reg); // [RQ11]
      CMD_ECHO_Q:       answer_data = bool_answer(echo_reg); // [RQ12]
      CMD_PACE_Q:       answer_data = bool_answer(pace_reg); // [RQ15]
      default:          answer_valid = 1'b0;
    endcase
  end

  // Summaries are taken from the next event value so they track reads at once
  wire logic oper_summary = summary_of(oper_event_next, oper_enable_reg); // [RQ1]
  wire logic ques_summary = summary_of(ques_event_next, ques_enable_reg); // [RQ7]

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cond_meta_reg <= 5'h00;
      cond_sync_reg <= 5'h00;
      cond_prev_reg <= 5'h00;
    end else begin
      cond_meta_reg <= cond_pins;
      cond_sync_reg <= cond_meta_reg;
      cond_prev_reg <= cond_sync_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      oper_event_reg <= 16'h0000;
      ques_event_reg <= 16'h0000;
    end else begin
      oper_event_reg <= oper_event_next; // [RQ18]
      ques_event_reg <= ques_event_next; // [RQ18]
    end
  end

  // Preset has priority; both can never come in one cycle anyway
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      oper_enable_reg <= `RST_OPER_ENABLE;
      ques_enable_reg <= `RST_QUES_ENABLE;
    end else if (do_preset) begin
      oper_enable_reg <= 16'h0000; // [RQ8]
      ques_enable_reg <= 16'h0000; // [RQ8]
    end else begin
      if (wr_oper_enab) begin
        oper_enable_reg <= cmd_data & `OPER_VALID_MASK; // [RQ2]
      end
      if (wr_ques_enab) begin
        ques_enable_reg <= cmd_data; // [RQ9]
      end
    end
  end

  // Out-of-range address or rate values leave the setting unchanged
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_addr_reg <= `RST_BUS_ADDR;
      baud_reg     <= BAUD_SEL_9600;
      pace_reg     <= `RST_PACE;
    end else begin
      if (wr_addr) begin
        bus_addr_reg <= cmd_data[4:0]; // [RQ10]
      end
      if (wr_baud) begin
        baud_reg <= baud_encode(cmd_data); // [RQ11]
      end
      if (wr_pace) begin
        pace_reg <= cmd_data[0]; // [RQ15]
      end
    end
  end

  // General reset has no branch here, so echo survives it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      echo_reg <= `RST_ECHO;
    end else if (wr_echo) begin
      echo_reg <= cmd_data[0]; // [RQ12] [RQ14]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      resp_valid_reg <= 1'b0;
      resp_data_reg  <= 16'h0000;
    end else begin
      resp_valid_reg <= answer_valid;
      if (answer_valid) begin
        resp_data_reg <= answer_data;
      end
    end
  end

  // Unused status byte bits are held at zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_byte_reg <= 8'h00;
    end else begin
      status_byte_reg                <= 8'h00;
      status_byte_reg[`STB_BIT_OPER] <= oper_summary; // [RQ1]
      status_byte_reg[`STB_BIT_QUES] <= ques_summary; // [RQ7]
    end
  end

  // Echo keeps its own line-end state
  echo_gate u_echo_gate (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .echo_on    (echo_reg),
    .rx_valid   (rx_valid),
    .rx_char    (rx_char),
    .echo_valid (echo_valid),
    .echo_char  (echo_char)
  );

  // Every output comes straight from a register
  assign resp_valid                   = resp_valid_reg;
  assign resp_data                    = resp_data_reg;
  assign status_byte                  = status_byte_reg;
  assign parallel_bus_address_setting = bus_addr_reg;
  assign serial_rate_setting          = baud_reg;
  assign serial_pacing_setting        = pace_reg;
  assign serial_echo_setting          = echo_reg;

endmodule

// File: hdl/status_regs.svh
// Field positions, reset values and constants of the status and serial setup block
`ifndef STATUS_REGS_SVH
`define STATUS_REGS_SVH

// Operation register bit positions
`define OPER_BIT_CAL        0
`define OPER_BIT_TRIG_WAIT  5
`define OPER_BIT_CONST_VOLT 8
`define OPER_BIT_CONST_CURR 10
`define OPER_VALID_MASK     16'h0521

// Questionable register bit positions
`define QUES_BIT_OVERTEMP   3
`define QUES_VALID_MASK     16'h0008

// Status byte summary positions
`define STB_BIT_OPER        7
`define STB_BIT_QUES        3

// Parallel bus address limits
`define ADDR_MIN            5'h01
`define ADDR_MAX            5'h1e

// Baud rate values as carried on the command data
`define BAUD_19200          16'h4b00
`define BAUD_9600           16'h2580
`define BAUD_4800           16'h12c0
`define BAUD_2400           16'h0960

// Boolean query answers
`define ANSWER_ON           16'h0001
`define ANSWER_OFF          16'h0000

// Line terminator that ends a pending echo
`define LINE_TERMINATOR     8'h0a

// Reset values
`define RST_OPER_ENABLE     16'h0000
`define RST_QUES_ENABLE     16'h0000
`define RST_BUS_ADDR        5'h06
`define RST_ECHO            1'b0
`define RST_PACE            1'b0

`endif

// File: hdl/status_pkg.sv
// Types shared by the status and serial setup block
package status_pkg;

  typedef enum logic [4:0] {
    CMD_NONE,
    CMD_OPER_COND_Q,
    CMD_OPER_ENAB_W,
    CMD_OPER_ENAB_Q,
    CMD_OPER_EVENT_Q,
    CMD_PRESET,
    CMD_QUES_EVENT_Q,
    CMD_QUES_COND_Q,
    CMD_QUES_ENAB_W,
    CMD_QUES_ENAB_Q,
    CMD_ADDR_W,
    CMD_ADDR_Q,
    CMD_BAUD_W,
    CMD_BAUD_Q,
    CMD_ECHO_W,
    CMD_ECHO_Q,
    CMD_PACE_W,
    CMD_PACE_Q,
    CMD_GENERAL_RESET
  } cmd_t;

  typedef enum logic [1:0] {
    BAUD_SEL_19200,
    BAUD_SEL_9600,
    BAUD_SEL_4800,
    BAUD_SEL_2400
  } baud_t;

  typedef enum logic {
    ECHO_IDLE,
    ECHO_ACTIVE
  } echo_state_t;

endpackage

// File: hdl/echo_gate.sv
// Serial character echo with deferred switch-off at line end
`timescale 1ns/1ps
`include "status_regs.svh"

module echo_gate (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Setting
  input  wire logic       echo_on,
  // Received characters
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_char,
  // Echoed characters
  output logic            echo_valid,
  output logic [7:0]      echo_char
);
  import status_pkg::*;

  echo_state_t state_reg;
  echo_state_t state_next;
  logic        echo_valid_reg;
  logic [7:0]  echo_char_reg;

  wire logic is_terminator = (rx_char == `LINE_TERMINATOR);
  wire logic echo_now      = rx_valid && (state_reg == ECHO_ACTIVE || echo_on);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ECHO_IDLE: begin
        if (echo_on) begin
          state_next = ECHO_ACTIVE; // [RQ12]
        end
      end
      ECHO_ACTIVE: begin
        // Switch-off only takes hold once the current line is finished
        if (!echo_on && rx_valid && is_terminator) begin
          state_next = ECHO_IDLE; // [RQ13]
        end
      end
      default: state_next = ECHO_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg      <= ECHO_IDLE;
      echo_valid_reg <= 1'b0;
      echo_char_reg  <= 8'h00;
    end else begin
      state_reg      <= state_next;
      echo_valid_reg <= echo_now; // [RQ12] [RQ13]
      if (echo_now) begin
        echo_char_reg <= rx_char;
      end
    end
  end

  assign echo_valid = echo_valid_reg;
  assign echo_char  = echo_char_reg;

endmodule

// File: tb/status_monitor.sv
// Port assertions for the status and serial setup block
`timescale 1ns/1ps
module status_monitor (
  // Clock and reset
  input wire logic             clk_sys,
  input wire logic             rst,
  // Commands and answers
  input wire logic             cmd_valid,
  input wire status_pkg::cmd_t cmd_code,
  input wire logic             resp_valid,
  input wire logic [15:0]      resp_data,
  // Status and settings
  input wire logic [7:0]       status_byte,
  input wire logic [4:0]       parallel_bus_address_setting,
  input wire logic             serial_pacing_setting,
  input wire logic             serial_echo_setting,
  // Character stream
  input wire logic             rx_valid,
  input wire logic [7:0]       rx_char,
  input wire logic             echo_valid,
  input wire logic [7:0]       echo_char
);
  import status_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Idle cycles read as code zero so a stale code never counts
  wire logic [4:0] live_cmd = cmd_valid ? cmd_code : 5'h00;

  query_answer_a: assert property (live_cmd == CMD_OPER_ENAB_Q |=> resp_valid)
    else $error("mask query gave no answer");
  write_quiet_a: assert property (live_cmd == CMD_QUES_ENAB_W |=> !resp_valid)
    else $error("mask write gave an answer");
  preset_clear_a: assert property (live_cmd == CMD_PRESET ##2
    live_cmd == CMD_OPER_ENAB_Q |=> resp_data == 16'h0000)
    else $error("mask not zero after preset");
  spare_bits_a: assert property ((status_byte & 8'h77) == 8'h00)
    else $error("unused status byte bit set");
  pace_answer_a: assert property (live_cmd == CMD_PACE_Q |=>
    resp_data == {15'h0000, serial_pacing_setting})
    else $error("pacing answer differs from setting");
  echo_on_a: assert property (rx_valid && serial_echo_setting |=>
    echo_valid && echo_char == $past(rx_char))
    else $error("character not echoed");
  no_echo_a: assert property (!rx_valid |=> !echo_valid)
    else $error("echo without a received character");
  reset_keeps_echo_a: assert property (live_cmd == CMD_GENERAL_RESET |=>
    $stable(serial_echo_setting))
    else $error("general reset changed echo");
  addr_range_a: assert property (parallel_bus_address_setting inside {[5'h01:5'h1e]})
    else $error("bus address out of range");
  addr_answer_a: assert property (live_cmd == CMD_ADDR_Q |=>
    resp_data == {11'h000, parallel_bus_address_setting})
    else $error("address answer differs from setting");
endmodule

bind status_serial_config status_monitor mon (.clk_sys, .rst, .cmd_valid, .cmd_code,
  .resp_valid, .resp_data, .status_byte, .parallel_bus_address_setting,
  .serial_pacing_setting, .serial_echo_setting, .rx_valid, .rx_char, .echo_valid,
  .echo_char);

// File: tb/host_model.sv
// Remote host controller issuing decoded commands
`timescale 1ns/1ps
module host_model (
  // Clock
  input  wire logic        clk_sys,
  // Commands
  output logic             cmd_valid,
  output status_pkg::cmd_t cmd_code,
  output logic [15:0]      cmd_data,
  // Answers
  input  wire logic        resp_valid,
  input  wire logic [15:0] resp_data
);
  import status_pkg::*;
  initial begin
    cmd_valid = 1'b0;
    cmd_code = CMD_NONE;
    cmd_data = 16'h0000;
  end
  // Held across one rising edge; released data is inverted so no stale value lingers
  task automatic send(input cmd_t c, input logic [15:0] d);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_data = d;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    cmd_code = CMD_NONE;
    cmd_data = ~d;
  endtask
  // Answer stands only in the cycle after the taking edge
  task automatic ask(input cmd_t c, output logic [15:0] r);
    send(c, 16'h0000);
    r = resp_valid ? resp_data : 16'hxxxx;
  endtask
endmodule

// File: tb/tb.sv
// Self-checking bench for the status and serial setup block
`timescale 1ns/1ps
module tb;
  import status_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst;
  logic        cmd_valid;
  cmd_t        cmd_code;
  logic [15:0] cmd_data;
  logic        resp_valid;
  logic [15:0] resp_data;
  logic        cal_pin, trig_pin, volt_pin, curr_pin, heat_pin;
  logic [7:0]  status_byte;
  logic [4:0]  parallel_bus_address_setting;
  baud_t       serial_rate_setting;
  logic        serial_pacing_setting, serial_echo_setting;
  logic        rx_valid, echo_valid;
  logic [7:0]  rx_char, echo_char;
  int          num_errors = 0, compares = 0, cycles = 0;

  always #5 clk_sys = ~clk_sys;

  status_serial_config dut (.clk_sys, .rst, .cmd_valid, .cmd_code, .cmd_data, .resp_valid,
    .resp_data, .calibration_busy_pin(cal_pin), .waiting_for_trigger_flag(trig_pin),
    .constant_voltage_flag(volt_pin), .constant_current_flag(curr_pin),
    .overtemperature_flag(heat_pin), .status_byte, .parallel_bus_address_setting,
    .serial_rate_setting, .serial_pacing_setting, .serial_echo_setting, .rx_valid,
    .rx_char, .echo_valid, .echo_char);
  host_model host (.clk_sys, .cmd_valid, .cmd_code, .cmd_data, .resp_valid, .resp_data);

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic rx(input logic [7:0] ch, input logic on);
    @(negedge clk_sys);
    rx_valid = 1'b1;
    rx_char = ch;
    @(negedge clk_sys);
    rx_valid = 1'b0;
    rx_char = ~ch;
    check({15'h0000, echo_valid}, {15'h0000, on});
    if (on) check({8'h00, echo_char}, {8'h00, ch});
  endtask

  task automatic t_masks;
    logic [15:0] r;
    host.send(CMD_OPER_ENAB_W, 16'h0420);
    host.ask(CMD_OPER_ENAB_Q, r);
    check(r, 16'h0420);
    host.send(CMD_QUES_ENAB_W, 16'h0003);
    host.ask(CMD_QUES_ENAB_Q, r);
    check(r, 16'h0003);
    host.send(CMD_PRESET, 16'h0000);
    host.ask(CMD_OPER_ENAB_Q, r);
    check(r, 16'h0000);
    host.ask(CMD_QUES_ENAB_Q, r);
    check(r, 16'h0000);
  endtask

  task automatic t_oper;
    logic [15:0] r;
    {cal_pin, trig_pin, volt_pin} = 3'b111;
    idle(4);
    check({8'h00, status_byte}, 16'h0000);
    host.send(CMD_OPER_ENAB_W, 16'h0521);
    idle(2);
    check({8'h00, status_byte}, 16'h0080);
    host.ask(CMD_OPER_COND_Q, r);
    check(r, 16'h0121);
    {cal_pin, volt_pin, curr_pin} = 3'b001;
    idle(4);
    host.ask(CMD_OPER_EVENT_Q, r);
    check(r, 16'h0521);
    host.ask(CMD_OPER_EVENT_Q, r);
    check(r, 16'h0000);
    check({8'h00, status_byte}, 16'h0000);
  endtask

  task automatic t_ques;
    logic [15:0] r;
    host.send(CMD_QUES_ENAB_W, 16'h0008);
    heat_pin = 1'b1;
    idle(4);
    check({8'h00, status_byte}, 16'h0008);
    host.ask(CMD_QUES_EVENT_Q, r);
    check(r, 16'h0008);
    host.ask(CMD_QUES_COND_Q, r);
    check(r, 16'h0008);
    heat_pin = 1'b0;
    idle(4);
    host.ask(CMD_QUES_EVENT_Q, r);
    check(r, 16'h0000);
    host.ask(CMD_QUES_COND_Q, r);
    check(r, 16'h0000);
    // Rise reaches the event register on the edge that takes the read
    heat_pin = 1'b1;
    idle(1);
    host.ask(CMD_QUES_EVENT_Q, r);
    check(r, 16'h0000);
    host.ask(CMD_QUES_EVENT_Q, r);
    check(r, 16'h0008);
    heat_pin = 1'b0;
  endtask

  task automatic t_echo;
    logic [15:0] r;
    host.send(CMD_ECHO_W, 16'h0001);
    host.ask(CMD_ECHO_Q, r);
    check(r, 16'h0001);
    host.send(CMD_GENERAL_RESET, 16'h0000);
    host.ask(CMD_ECHO_Q, r);
    check(r, 16'h0001);
    rx(8'h41, 1'b1);
    host.send(CMD_ECHO_W, 16'h0000);
    host.ask(CMD_ECHO_Q, r);
    check(r, 16'h0000);
    rx(8'h42, 1'b1);
    rx(8'h0a, 1'b1);
    rx(8'h43, 1'b0);
  endtask

  task automatic t_cfg;
    logic [15:0] r;
    logic [15:0] rate [4] = '{16'h4b00, 16'h2580, 16'h12c0, 16'h0960};
    for (int i = 0; i < 4; i++) begin
      host.send(CMD_BAUD_W, rate[i]);
      host.ask(CMD_BAUD_Q, r);
      check(r, rate[i]);
      check({14'h0000, serial_rate_setting}, i[15:0]);
    end
    host.send(CMD_BAUD_W, 16'h1234);
    host.ask(CMD_BAUD_Q, r);
    check(r, 16'h0960);
    host.send(CMD_ADDR_W, 16'h001e);
    host.send(CMD_ADDR_W, 16'h001f);
    host.ask(CMD_ADDR_Q, r);
    check(r, 16'h001e);
    host.send(CMD_PACE_W, 16'h0001);
    host.ask(CMD_PACE_Q, r);
    check(r, 16'h0001);
    host.send(CMD_PACE_W, 16'h0000);
    host.ask(CMD_PACE_Q, r);
    check(r, 16'h0000);
  endtask

  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      complete_run;
    end
  end

  initial begin
    rst = 1'b1;
    {cal_pin, trig_pin, volt_pin, curr_pin, heat_pin} = 5'h00;
    rx_valid = 1'b0;
    rx_char = 8'h00;
    idle(20);
    rst = 1'b0;
    check({8'h00, parallel_bus_address_setting, serial_rate_setting,
           serial_pacing_setting}, 16'h0032);
    t_masks;
    t_oper;
    t_ques;
    t_echo;
    t_cfg;
    complete_run;
  end
endmodule
